// File: tmps_defines.svh
/*
 * Register offsets, field positions, reset values and divider counts for
 * the 16-bit interval timer. Assumes an 8-bit register port with byte
 * addresses taken as printed.
 */
`ifndef TMPS_DEFINES_SVH
`define TMPS_DEFINES_SVH
// Register byte addresses on the plain port.
`define TMPS_ADDR_PORT_DIR 16'hFF20
`define TMPS_ADDR_PRESCALE 16'hFFBB
`define TMPS_ADDR_MODE_CTL 16'hFFBA
`define TMPS_ADDR_OUT_CTL 16'hFFBD
`define TMPS_ADDR_CMP_A_LO 16'hFFB0
`define TMPS_ADDR_CMP_A_HI 16'hFFB1
`define TMPS_ADDR_CMP_B_LO 16'hFFB2
`define TMPS_ADDR_CMP_B_HI 16'hFFB3
`define TMPS_ADDR_COUNT_LO 16'hFFB4
`define TMPS_ADDR_COUNT_HI 16'hFFB5
`define TMPS_ADDR_STATUS 16'hFFB6
// Reset values.
`define TMPS_RST_PORT_DIR 8'hFF
`define TMPS_RST_PRESCALE 8'h00
`define TMPS_RST_MODE_CTL 8'h00
`define TMPS_RST_OUT_CTL 8'h00
// Field positions.
`define TMPS_CLK_SEL_LSB 0
`define TMPS_EDGE_A_LSB 4
`define TMPS_EDGE_B_LSB 6
`define TMPS_RUN_MODE_LSB 2
`define TMPS_OUT_EN_BIT 0
`define TMPS_INV_A_BIT 1
`define TMPS_PIN_A_BIT 0
`define TMPS_PIN_B_BIT 1
`define TMPS_STAT_OVF_BIT 0
`define TMPS_STAT_IRQA_BIT 1
`define TMPS_STAT_IRQB_BIT 2
`define TMPS_STAT_EDGE_B_BIT 3
// Prescaler terminal counts: the low two bits end a divide-by-4 period,
// all eight bits end a divide-by-256 period.
`define TMPS_DIV4_LAST 2'h3
`define TMPS_DIV256_LAST 8'hFF
`endif

// File: tmps_pkg.sv
/*
 * Types shared by the timer. Assumes tmps_defines.svh for numbers.
 */
package tmps_pkg;
	// Counter run modes held in the mode-control register.
	typedef enum logic [1:0] {
		TMPS_RUN_STOP = 2'h0,
		TMPS_RUN_FREE = 2'h1,
		TMPS_RUN_EXT_CLR = 2'h2,
		TMPS_RUN_CLR_A = 2'h3
	} tmps_run_type;
	// Edge selections for the two edge inputs.
	typedef enum logic [1:0] {
		TMPS_EDGE_FALL = 2'h0,
		TMPS_EDGE_RISE = 2'h1,
		TMPS_EDGE_BAD = 2'h2,
		TMPS_EDGE_BOTH = 2'h3
	} tmps_edge_type;
	// Timer activity, one-hot.
	typedef enum logic [1:0] {
		TMPS_ST_IDLE = 2'b01,
		TMPS_ST_RUN = 2'b10
	} tmps_state_type;
endpackage : tmps_pkg

// File: tmps_timer.sv
/*
 * 16-bit timer with prescaler, edge detection on two inputs, interval
 * clearing on compare A and square-wave output. Assumes a single 25 MHz
 * clock, synchronous pins and a register master that never waits.
 */
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "tmps_defines.svh"

// How it works
// - Reset clears prescale register to zero.
// - Edge B field: fall, rise, both.
// - Edge A field uses same encoding.
// - Clock select: clk, /4, /256, edge A.
// - High input at first start gives rise.
// - Restart gives no spurious rising edge.
// - Direction bit 0 drives; high nibble reads one.
// - Reset sets port direction to FFH.
// - Mode 11 counts on selected clock.
// - Match A clears counter, raises irq A.
// - Irq A every M+1 count clocks.
// - Compare B match still raises irq B.
// - Match A toggles output pin.
// - Output disabled holds pin low.
// - Irq A raised regardless of inversion.
// - Overflow flag on FFFFH wrap.
module tmps_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic edge_input_a,
	input wire logic edge_input_b,
	output logic timer_output_pin,
	output logic [3:0] port_out_en,
	output logic compare_a_irq,
	output logic compare_b_irq
);
	// Software registers.
	logic [7:0] port_direction_q;
	logic [7:0] prescale_edge_select_q;
	logic [7:0] mode_control_q;
	logic [7:0] output_control_q;
	logic [15:0] compare_a_q;
	logic [15:0] compare_b_q;
	// Counter, prescaler and pin state.
	logic [15:0] timer_count_q;
	logic [7:0] presc_q;
	logic overflow_flag_q;
	logic out_level_q;
	logic in_a_q;
	logic in_b_q;
	logic started_once_q;
	logic edge_b_seen_q; // Sticky record of a valid edge on input B.
	tmps_pkg::tmps_state_type state_q;

	// Field decode.
	wire [1:0] clk_sel = prescale_edge_select_q[`TMPS_CLK_SEL_LSB +: 2];
	wire [1:0] edge_a_sel = prescale_edge_select_q[`TMPS_EDGE_A_LSB +: 2];
	wire [1:0] edge_b_sel = prescale_edge_select_q[`TMPS_EDGE_B_LSB +: 2];
	wire [1:0] run_mode = mode_control_q[`TMPS_RUN_MODE_LSB +: 2];
	wire running = run_mode != 2'h0;
	wire start_now = running && state_q == tmps_pkg::TMPS_ST_IDLE;

	// Valid edge per selection; the prohibited code detects nothing.
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = !prev && cur;
		fall = prev && !cur;
		case (sel)
			2'h0: edge_hit = fall;
			2'h1: edge_hit = rise;
			2'h3: edge_hit = rise || fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// On the very first start the previous level counts as low, so a high
	// input shows as a rising edge; later starts use the true history.
	wire prev_a = (start_now && !started_once_q) ? 1'b0 : in_a_q;
	wire prev_b = (start_now && !started_once_q) ? 1'b0 : in_b_q;
	wire edge_a = running && edge_hit(edge_a_sel, prev_a, edge_input_a);
	wire edge_b = running && edge_hit(edge_b_sel, prev_b, edge_input_b);

	// Count-clock enable from the selected source. The divide-by-4 end
	// looks only at the low prescaler bits, so both rates share one counter.
	wire div4_end = presc_q[1:0] == `TMPS_DIV4_LAST;
	wire div256_end = presc_q == `TMPS_DIV256_LAST;
	wire tick = (clk_sel == 2'h0) ? running :
		(clk_sel == 2'h1) ? running && div4_end :
		(clk_sel == 2'h2) ? running && div256_end :
		edge_a;

	wire match_a = running && tick && timer_count_q == compare_a_q;
	wire match_b = running && tick && timer_count_q == compare_b_q;
	wire clr_on_a = match_a && run_mode == 2'h3;
	wire wrap = tick && !clr_on_a && timer_count_q == 16'hFFFF;
	wire out_enable = output_control_q[`TMPS_OUT_EN_BIT];
	wire invert_on_match_a = output_control_q[`TMPS_INV_A_BIT];

	// Register write decode.
	wire wr_dir = reg_wr && reg_addr == `TMPS_ADDR_PORT_DIR;
	wire wr_pre = reg_wr && reg_addr == `TMPS_ADDR_PRESCALE;
	wire wr_mode = reg_wr && reg_addr == `TMPS_ADDR_MODE_CTL;
	wire wr_out = reg_wr && reg_addr == `TMPS_ADDR_OUT_CTL;
	wire wr_stat = reg_wr && reg_addr == `TMPS_ADDR_STATUS;
	// Compare bytes are written one at a time; no pairing latch is kept.
	wire wr_cal = reg_wr && reg_addr == `TMPS_ADDR_CMP_A_LO;
	wire wr_cah = reg_wr && reg_addr == `TMPS_ADDR_CMP_A_HI;
	wire wr_cbl = reg_wr && reg_addr == `TMPS_ADDR_CMP_B_LO;
	wire wr_cbh = reg_wr && reg_addr == `TMPS_ADDR_CMP_B_HI;

	// Status byte: overflow in bit 0, edge B seen in bit 3.
	wire [7:0] status_byte = {4'h0, edge_b_seen_q, 2'b00, overflow_flag_q};

	// Read mux; unmapped addresses read zero.
	logic [7:0] rdata_d;
	always_comb begin
		case (reg_addr)
			`TMPS_ADDR_PORT_DIR: rdata_d = {4'hF, port_direction_q[3:0]};
			`TMPS_ADDR_PRESCALE: rdata_d = prescale_edge_select_q;
			`TMPS_ADDR_MODE_CTL: rdata_d = mode_control_q;
			`TMPS_ADDR_OUT_CTL: rdata_d = output_control_q;
			`TMPS_ADDR_CMP_A_LO: rdata_d = compare_a_q[7:0];
			`TMPS_ADDR_CMP_A_HI: rdata_d = compare_a_q[15:8];
			`TMPS_ADDR_CMP_B_LO: rdata_d = compare_b_q[7:0];
			`TMPS_ADDR_CMP_B_HI: rdata_d = compare_b_q[15:8];
			`TMPS_ADDR_COUNT_LO: rdata_d = timer_count_q[7:0];
			`TMPS_ADDR_COUNT_HI: rdata_d = timer_count_q[15:8];
			`TMPS_ADDR_STATUS: rdata_d = status_byte;
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
		end
	end

	// Software registers. Prescale is not write-protected in hardware;
	// keeping it still while running is the programmer's duty.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			port_direction_q <= `TMPS_RST_PORT_DIR;
			prescale_edge_select_q <= `TMPS_RST_PRESCALE;
			mode_control_q <= `TMPS_RST_MODE_CTL;
			output_control_q <= `TMPS_RST_OUT_CTL;
			compare_a_q <= 16'h0000;
			compare_b_q <= 16'h0000;
		end else begin
			if (wr_dir) port_direction_q <= {4'hF, reg_wdata[3:0]};
			if (wr_pre) prescale_edge_select_q <= reg_wdata;
			if (wr_mode) mode_control_q <= reg_wdata;
			if (wr_out) output_control_q <= reg_wdata;
			if (wr_cal) compare_a_q[7:0] <= reg_wdata;
			if (wr_cah) compare_a_q[15:8] <= reg_wdata;
			if (wr_cbl) compare_b_q[7:0] <= reg_wdata;
			if (wr_cbh) compare_b_q[15:8] <= reg_wdata;
		end
	end

	// Activity state and first-start memory used by the edge detectors.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= tmps_pkg::TMPS_ST_IDLE;
			started_once_q <= 1'b0;
			in_a_q <= 1'b0;
			in_b_q <= 1'b0;
		end else begin
			in_a_q <= edge_input_a;
			in_b_q <= edge_input_b;
			case (state_q)
				tmps_pkg::TMPS_ST_IDLE: if (running) begin
					state_q <= tmps_pkg::TMPS_ST_RUN;
					started_once_q <= 1'b1;
				end
				tmps_pkg::TMPS_ST_RUN: if (!running) state_q <= tmps_pkg::TMPS_ST_IDLE;
				default: state_q <= tmps_pkg::TMPS_ST_IDLE;
			endcase
		end
	end

	// Prescaler and counter; stopping holds both at zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			presc_q <= 8'h00;
			timer_count_q <= 16'h0000;
		end else if (!running) begin
			presc_q <= 8'h00;
			timer_count_q <= 16'h0000;
		end else begin
			presc_q <= presc_q + 8'h01;
			if (clr_on_a) timer_count_q <= 16'h0000;
			else if (tick) timer_count_q <= timer_count_q + 16'h0001;
		end
	end

	// Overflow flag: set wins over a software clear; stop also clears.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overflow_flag_q <= 1'b0;
		end else if (wrap) begin
			overflow_flag_q <= 1'b1;
		end else if (!running) begin
			overflow_flag_q <= 1'b0;
		end else if (wr_stat) begin
			overflow_flag_q <= reg_wdata[`TMPS_STAT_OVF_BIT];
		end
	end

	// Edge B seen flag: as with overflow, a detected edge beats a software
	// clear in the same cycle so that no event is lost; stop clears it.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edge_b_seen_q <= 1'b0;
		end else if (edge_b) begin
			edge_b_seen_q <= 1'b1;
		end else if (!running) begin
			edge_b_seen_q <= 1'b0;
		end else if (wr_stat) begin
			edge_b_seen_q <= reg_wdata[`TMPS_STAT_EDGE_B_BIT];
		end
	end

	// Interrupt pulses and output pin, all registered.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			compare_a_irq <= 1'b0;
			compare_b_irq <= 1'b0;
			out_level_q <= 1'b0;
			timer_output_pin <= 1'b0;
			port_out_en <= 4'h0;
		end else begin
			compare_a_irq <= match_a;
			compare_b_irq <= match_b;
			if (!out_enable) out_level_q <= 1'b0;
			else if (match_a && invert_on_match_a) out_level_q <= !out_level_q;
			timer_output_pin <= out_enable && out_level_q;
			port_out_en <= ~port_direction_q[3:0];
		end
	end

	// Compare A match pulses irq A one cycle later.
	AST_IRQ_A: assert property (@(posedge ref_clk) disable iff (rst)
		match_a |=> compare_a_irq)
		else $error("irq A missing");
	// In clear-on-A mode a match returns the counter to zero.
	AST_CLR_A: assert property (@(posedge ref_clk) disable iff (rst)
		clr_on_a |=> timer_count_q == 16'h0000)
		else $error("no clear");
	// Compare B stays live in interval operation.
	AST_IRQ_B: assert property (@(posedge ref_clk) disable iff (rst)
		match_b |=> compare_b_irq)
		else $error("irq B missing");
	// A wrap always leaves the overflow flag set.
	AST_OVF: assert property (@(posedge ref_clk) disable iff (rst)
		wrap |=> overflow_flag_q)
		else $error("no overflow");
	// A disabled output holds the pin low.
	AST_LOW: assert property (@(posedge ref_clk) disable iff (rst)
		!out_enable |=> !timer_output_pin)
		else $error("pin not low");
	// An enabled inversion flips the level on every match A.
	AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (rst)
		match_a && out_enable && invert_on_match_a && $stable(output_control_q)
		|=> out_level_q != $past(out_level_q))
		else $error("no toggle");
	// Without inversion a match leaves the level alone.
	AST_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
		match_a && out_enable && !invert_on_match_a
		|=> out_level_q == $past(out_level_q))
		else $error("level changed");
	// The pin shows the held level one cycle later while enabled.
	AST_PIN: assert property (@(posedge ref_clk) disable iff (rst)
		out_enable |=> timer_output_pin == $past(out_level_q))
		else $error("pin not level");
	// Stopping holds counter and prescaler at zero.
	AST_STOP: assert property (@(posedge ref_clk) disable iff (rst)
		!running |=> timer_count_q == 16'h0000 && presc_q == 8'h00)
		else $error("stop not zero");
	// A direction write reaches the drive enables two cycles later.
	AST_DIR: assert property (@(posedge ref_clk) disable iff (rst)
		wr_dir |=> ##1 port_out_en == ~$past(reg_wdata[3:0], 2))
		else $error("direction wrong");
	// A direction write keeps the high nibble at ones.
	AST_DIR_HI: assert property (@(posedge ref_clk) disable iff (rst)
		wr_dir |=> port_direction_q[7:4] == 4'hF &&
		port_direction_q[3:0] == $past(reg_wdata[3:0]))
		else $error("direction high bits");
	// Divide by 4 leaves three quiet cycles after each tick.
	AST_DIV4: assert property (@(posedge ref_clk) disable iff (rst)
		running && clk_sel == 2'h1 && tick |=> !tick [*3])
		else $error("div4 wrong");
	// A detected edge on input B is always recorded.
	AST_EDGE_B: assert property (@(posedge ref_clk) disable iff (rst)
		edge_b |=> edge_b_seen_q)
		else $error("edge B lost");
	// A restart judges input A against its real history.
	AST_RESTART: assert property (@(posedge ref_clk) disable iff (rst)
		start_now && started_once_q && in_a_q && edge_input_a
		|-> !edge_a)
		else $error("spurious edge A");
endmodule : tmps_timer

// File: tmps_pin_model.sv
/*
 * Pin-side model: a pulse source on the first edge input, a second edge
 * input that follows the idle level and a load counting timer output
 * changes. Assumes the bench
 * raises fire for one cycle just after a rising edge of ref_clk.
 */
`timescale 1ns/10ps
module tmps_pin_model (
	input wire logic ref_clk,
	input wire logic pin_out,
	input wire logic fire,
	input wire logic idle_lvl,
	output logic edge_a,
	output logic edge_b,
	output logic [15:0] n_toggle
);
	// Last pin level seen by the load, and its count of level changes.
	logic prev_q = 1'b0;
	logic [15:0] cnt_q = 16'h0000;
	assign n_toggle = cnt_q;
	// Three pulses, each four clocks high and low, wide enough to count.
	// The second input follows the idle level; the bench keeps it low
	// whenever the timer output owns the shared pin.
	initial begin
		edge_a = 1'b0;
		edge_b = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (fire === 1'b1) begin
				repeat (3) begin
					edge_a <= 1'b1;
					repeat (4) @(posedge ref_clk);
					edge_a <= 1'b0;
					repeat (4) @(posedge ref_clk);
				end
			end else begin
				edge_a <= idle_lvl;
				edge_b <= idle_lvl;
			end
		end
	end
	// The load counts level changes; only differences are ever used.
	always @(posedge ref_clk) begin
		prev_q <= pin_out;
		if (prev_q !== pin_out) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule : tmps_pin_model

// File: timer16_prescale_interval_square_tb.sv
/*
 * Self-checking bench for the interval timer.
 * Assumes tmps_timer, tmps_pin_model and tmps_defines.svh.
 */
`timescale 1ns/10ps
`include "tmps_defines.svh"
module timer16_prescale_interval_square_tb;
	logic ref_clk, rst, reg_wr, reg_rd, edge_input_a, edge_input_b;
	logic timer_output_pin, compare_a_irq, compare_b_irq, fire, idle_lvl;
	logic [15:0] reg_addr, d, g, n_toggle, t0;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] port_out_en;
	logic [15:0] n_edge [4] = '{16'h0003, 16'h0003, 16'h0000, 16'h0006};
	logic [15:0] div [3] = '{16'h0001, 16'h0004, 16'h0100};
	int n_fail, checks_done;
	tmps_timer DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .edge_input_a(edge_input_a),
		.edge_input_b(edge_input_b), .timer_output_pin(timer_output_pin),
		.port_out_en(port_out_en), .compare_a_irq(compare_a_irq),
		.compare_b_irq(compare_b_irq));
	tmps_pin_model PINS (.ref_clk(ref_clk), .pin_out(timer_output_pin),
		.fire(fire), .idle_lvl(idle_lvl), .edge_a(edge_input_a),
		.edge_b(edge_input_b), .n_toggle(n_toggle));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the read edge.
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = {8'h00, reg_rdata};
	endtask : rd
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Counts clocks up to the next interrupt pulse, bounded.
	task automatic gap(input logic b, output logic [15:0] n);
		n = 16'h0000;
		do begin
			@(posedge ref_clk);
			#1 n = n + 16'h0001;
		end while ((b ? compare_b_irq : compare_a_irq) !== 1'b1 &&
			n < 16'h1000);
	endtask : gap
	task automatic t_regs();
		rd(`TMPS_ADDR_PORT_DIR, g);
		chk("dir reset", 16'h00FF, g);
		chk("drive reset", 16'h0000, {12'h000, port_out_en});
		rd(`TMPS_ADDR_PRESCALE, g);
		chk("prescale reset", 16'h0000, g);
		wr(`TMPS_ADDR_PORT_DIR, 8'h0D);
		rd(`TMPS_ADDR_PORT_DIR, g);
		chk("dir write", 16'h00FD, g);
		chk("drive", 16'h0002, {12'h000, port_out_en});
		rd(16'h0000, g);
		chk("unmapped", 16'h0000, g);
		$display("register test done");
	endtask : t_regs
	// The first start ever must see a high input as a rising edge.
	task automatic t_edges();
		idle_lvl <= 1'b1;
		wr(`TMPS_ADDR_PRESCALE, 8'h53);
		wr(`TMPS_ADDR_MODE_CTL, 8'h04);
		repeat (10) @(posedge ref_clk);
		rd(`TMPS_ADDR_COUNT_LO, g);
		chk("first start", 16'h0001, g);
		rd(`TMPS_ADDR_STATUS, g);
		chk("edge b first", 16'h0008, g & 16'h0008);
		wr(`TMPS_ADDR_MODE_CTL, 8'h00);
		rd(`TMPS_ADDR_COUNT_LO, g);
		chk("stopped", 16'h0000, g);
		wr(`TMPS_ADDR_MODE_CTL, 8'h04);
		repeat (10) @(posedge ref_clk);
		idle_lvl <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rd(`TMPS_ADDR_COUNT_LO, g);
		chk("restart", 16'h0000, g);
		rd(`TMPS_ADDR_STATUS, g);
		chk("edge b restart", 16'h0000, g & 16'h0008);
		for (int k = 0; k < 4; k++) begin
			wr(`TMPS_ADDR_MODE_CTL, 8'h00);
			wr(`TMPS_ADDR_PRESCALE, {2'b00, 2'(k), 4'h3});
			wr(`TMPS_ADDR_MODE_CTL, 8'h04);
			fire <= 1'b1;
			@(posedge ref_clk);
			fire <= 1'b0;
			repeat (40) @(posedge ref_clk);
			rd(`TMPS_ADDR_COUNT_LO, g);
			chk("edge count", n_edge[k], g);
		end
		wr(`TMPS_ADDR_MODE_CTL, 8'h00);
		$display("edge test done");
	endtask : t_edges
	task automatic t_interval();
		wr(`TMPS_ADDR_CMP_A_LO, 8'h05);
		wr(`TMPS_ADDR_CMP_A_HI, 8'h00);
		wr(`TMPS_ADDR_CMP_B_LO, 8'h03);
		wr(`TMPS_ADDR_CMP_B_HI, 8'h00);
		wr(`TMPS_ADDR_OUT_CTL, 8'h03);
		for (int k = 2; k >= 0; k--) begin
			wr(`TMPS_ADDR_MODE_CTL, 8'h00);
			wr(`TMPS_ADDR_PRESCALE, 8'(k));
			wr(`TMPS_ADDR_MODE_CTL, 8'h0C);
			gap(1'b0, d);
			gap(1'b0, d);
			chk("gap a", 16'h0006 * div[k], d);
		end
		gap(1'b1, d);
		gap(1'b1, d);
		chk("gap b", 16'h0006, d);
		for (int k = 0; k < 2; k++) begin
			gap(1'b0, d);
			repeat (3) @(posedge ref_clk);
			#1 t0 = n_toggle;
			repeat (4) gap(1'b0, d);
			chk("gap", 16'h0006, d);
			repeat (3) @(posedge ref_clk);
			chk("toggles", t0 + 16'h0004 * 16'(1 - k), n_toggle);
			wr(`TMPS_ADDR_OUT_CTL, 8'h01);
		end
		wr(`TMPS_ADDR_OUT_CTL, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk("pin off", 16'h0000, {15'h0000, timer_output_pin});
		wr(`TMPS_ADDR_MODE_CTL, 8'h00);
		$display("interval test done");
	endtask : t_interval
	// A full free-run lap must raise the overflow flag.
	task automatic t_ovf();
		wr(`TMPS_ADDR_PRESCALE, 8'h00);
		wr(`TMPS_ADDR_MODE_CTL, 8'h04);
		rd(`TMPS_ADDR_STATUS, g);
		chk("ovf clear", 16'h0000, g & 16'h0001);
		repeat (65540) @(posedge ref_clk);
		rd(`TMPS_ADDR_STATUS, g);
		chk("ovf set", 16'h0001, g & 16'h0001);
		wr(`TMPS_ADDR_STATUS, 8'h00);
		rd(`TMPS_ADDR_STATUS, g);
		chk("ovf cleared", 16'h0000, g & 16'h0001);
		wr(`TMPS_ADDR_STATUS, 8'h01);
		rd(`TMPS_ADDR_STATUS, g);
		chk("ovf written", 16'h0001, g & 16'h0001);
		$display("overflow test done");
	endtask : t_ovf
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (95000) @(posedge ref_clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{rst, reg_wr, reg_rd, fire, idle_lvl} = 5'b10000;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_edges();
		t_interval();
		t_ovf();
		end_of_test();
	end
endmodule : timer16_prescale_interval_square_tb
